/* logic/anacmp_defs.vh */
// constants for the analog comparator control block
// Functional notes
// - Three comparator units work independently, each able to raise an interrupt or trigger the converter; zero and one can also drive an output.
// - Interrupt and converter-trigger detection are separate paths, each with its own edge or level condition.
// - Each comparator's minus input is always its own dedicated external minus pin.
// - Plus source code 00 picks the own plus pin, 01 comparator zero's plus pin, 10 the internal reference, 11 is reserved.
// - Comparator zero drives a dedicated output pin, comparator one drives its shared plus pin only while its plus source code is not 00, comparator two has no pin.
// - Each comparator has its own control and status register, and one shared reference control register serves all.
// - Interrupts use a masked status, a raw status and an enable register, one bit per comparator.
// - With the reference disabled the reference is ground whatever the tap setting.
// - Enabled with low range, the ladder is 31 units and the tap gives supply times (tap plus 8) over 31.
// - Enabled with high range, the ladder is 23 units and the tap gives supply times tap over 23.
// - A raw status bit sets on its comparator's interrupt condition regardless of enable and is read only.
// - A masked status bit shows the enabled pending interrupt, writing one clears it and zero does nothing.
`ifndef ANACMP_DEFS_VH
`define ANACMP_DEFS_VH
// plus source codes
`define ANACMP_SRC_OWN 2'h0
`define ANACMP_SRC_CMP0 2'h1
`define ANACMP_SRC_VREF 2'h2
`define ANACMP_SRC_RSVD 2'h3
// event sense codes, shared by interrupt and trigger paths
`define ANACMP_SENSE_LEVEL 2'h0
`define ANACMP_SENSE_FALL 2'h1
`define ANACMP_SENSE_RISE 2'h2
`define ANACMP_SENSE_BOTH 2'h3
// control register field positions
`define ANACMP_CTL_INV 1
`define ANACMP_CTL_ISEN_LO 2
`define ANACMP_CTL_ISLVAL 4
`define ANACMP_CTL_TSEN_LO 5
`define ANACMP_CTL_TSLVAL 7
`define ANACMP_CTL_SRC_LO 9
`define ANACMP_CTL_TOEN 11
`define ANACMP_CTL_WIDTH 12
`define ANACMP_CTL_RESET 12'h000
// reference control field positions
`define ANACMP_REF_TAP_LO 0
`define ANACMP_REF_RNG 8
`define ANACMP_REF_EN 9
`define ANACMP_REF_WIDTH 10
`define ANACMP_REF_RESET 10'h000
// ladder totals and offset in unit resistors
`define ANACMP_LADDER_LOW 5'h1f
`define ANACMP_LADDER_HIGH 5'h17
`define ANACMP_TAP_OFFSET 5'h08
`endif

/* logic/anacmp_top.v */
// control logic around three analog comparators
`timescale 1ns/1ps
`include "anacmp_defs.vh"
module anacmp_top
(
  input wire clk,
  input wire rst_n,
  // analog comparator results from the analog macro, asynchronous
  input wire [2:0] compare_result,
  // pad state of comparator one's shared pin, read as its plus input when not driven
  input wire cmp_one_plus_pin_in,
  // per-comparator control register writes
  input wire [2:0] ctl_wr,
  input wire [`ANACMP_CTL_WIDTH*3-1:0] ctl_wdata,
  // reference control register write
  input wire ref_wr,
  input wire [`ANACMP_REF_WIDTH-1:0] ref_wdata,
  // interrupt enable register write
  input wire irq_enable_wr,
  input wire [2:0] irq_enable_wdata,
  // masked status write-one-to-clear
  input wire masked_irq_wr,
  input wire [2:0] masked_irq_wdata,
  // register read back
  output reg [`ANACMP_CTL_WIDTH*3-1:0] comparator_control_reg,
  output reg [2:0] comparator_status_reg,
  output reg [`ANACMP_REF_WIDTH-1:0] reference_control_reg,
  output reg [2:0] irq_enable_reg,
  output reg [2:0] raw_irq_status_reg,
  output reg [2:0] masked_irq_status_reg,
  output reg irq,
  // analog routing controls
  output reg [5:0] positive_source_select,
  output reg [2:0] plus_own_connect,
  output reg [2:0] plus_cmp0_connect,
  output reg [2:0] plus_vref_connect,
  output reg [2:0] minus_input_connect,
  output reg ref_ladder_enable,
  output reg reference_range_select,
  output reg [3:0] ref_tap,
  output reg [4:0] ref_tap_units,
  output reg [4:0] ref_ladder_units,
  // output pins
  output reg cmp_zero_output_pin,
  output reg cmp_zero_output_oe,
  output reg cmp_one_output_pin,
  output reg cmp_one_output_oe,
  // converter trigger pulses
  output reg [2:0] adc_trigger
);

  reg [2:0] sync_a;
  reg [2:0] sync_b;
  reg [2:0] prev;
  reg [2:0] irq_event;
  reg [2:0] trg_event;
  reg [2:0] next_raw;
  reg [2:0] next_masked;
  reg [2:0] next_enable;
  reg [2:0] inv_val;
  reg [2:0] prev_inv;
  reg [`ANACMP_CTL_WIDTH-1:0] ctl_i;
  // one loop index per process, so no variable has two drivers
  integer i;
  integer j;
  integer k;

  // event detector: sense code against current and previous levels
  function sense_hit;
    input [1:0] sense;
    input level_val;
    input cur;
    input old;
    begin
      case (sense)
        `ANACMP_SENSE_LEVEL: sense_hit = (cur == level_val);
        `ANACMP_SENSE_FALL: sense_hit = old & ~cur;
        `ANACMP_SENSE_RISE: sense_hit = ~old & cur;
        `ANACMP_SENSE_BOTH: sense_hit = old ^ cur;
        default: sense_hit = 1'b0;
      endcase
    end
  endfunction

  // control field of comparator n
  function [`ANACMP_CTL_WIDTH-1:0] ctl_of;
    input [`ANACMP_CTL_WIDTH*3-1:0] all;
    input integer n;
    begin
      ctl_of = all[n*`ANACMP_CTL_WIDTH +: `ANACMP_CTL_WIDTH];
    end
  endfunction

  // --------------------------------------------------------------------
  // synchroniser and edge history
  // --------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      prev <= 3'h0;
    end
    else
    begin
      sync_a <= compare_result;
      sync_b <= sync_a;
      prev <= inv_val;
    end
  end

  // --------------------------------------------------------------------
  // event detection, separate paths for interrupt and trigger
  // --------------------------------------------------------------------
  always @*
  begin
    irq_event = 3'h0;
    trg_event = 3'h0;
    inv_val = 3'h0;
    prev_inv = prev;
    ctl_i = {`ANACMP_CTL_WIDTH{1'b0}};
    for (k = 0; k < 3; k = k + 1)
    begin
      ctl_i = ctl_of(comparator_control_reg, k);
      inv_val[k] = sync_b[k] ^ ctl_i[`ANACMP_CTL_INV];
      // each unit handled alone
      irq_event[k] = sense_hit(ctl_i[`ANACMP_CTL_ISEN_LO +: 2], ctl_i[`ANACMP_CTL_ISLVAL],
        inv_val[k], prev_inv[k]);
      trg_event[k] = sense_hit(ctl_i[`ANACMP_CTL_TSEN_LO +: 2], ctl_i[`ANACMP_CTL_TSLVAL],
        inv_val[k], prev_inv[k]) & ctl_i[`ANACMP_CTL_TOEN];
    end
  end

  // --------------------------------------------------------------------
  // interrupt status: set wins over clear
  // --------------------------------------------------------------------
  always @*
  begin
    next_raw = raw_irq_status_reg;
    if (masked_irq_wr)
    begin
      next_raw = raw_irq_status_reg & ~masked_irq_wdata;
    end
    next_raw = next_raw | irq_event;
    // enable as it stands after this edge, so masked never lags a new enable
    next_enable = irq_enable_reg;
    if (irq_enable_wr)
    begin
      next_enable = irq_enable_wdata;
    end
    next_masked = next_raw & next_enable;
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      comparator_control_reg <= {3{`ANACMP_CTL_RESET}};
      reference_control_reg <= `ANACMP_REF_RESET;
      irq_enable_reg <= 3'h0;
    end
    else
    begin
      for (j = 0; j < 3; j = j + 1)
      begin
        if (ctl_wr[j])
        begin
          comparator_control_reg[j*`ANACMP_CTL_WIDTH +: `ANACMP_CTL_WIDTH] <=
            ctl_wdata[j*`ANACMP_CTL_WIDTH +: `ANACMP_CTL_WIDTH];
        end
      end
      if (ref_wr)
      begin
        reference_control_reg <= ref_wdata;
      end
      if (irq_enable_wr)
      begin
        irq_enable_reg <= irq_enable_wdata;
      end
    end
  end

  // --------------------------------------------------------------------
  // interrupt status registers
  // --------------------------------------------------------------------
  // raw and masked load together, so masked always equals raw and enable
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      raw_irq_status_reg <= 3'h0;
      masked_irq_status_reg <= 3'h0;
      irq <= 1'b0;
    end
    else
    begin
      raw_irq_status_reg <= next_raw;
      masked_irq_status_reg <= next_masked;
      irq <= |next_masked;
    end
  end

  // --------------------------------------------------------------------
  // comparator status and converter trigger
  // --------------------------------------------------------------------
  // trigger pulses come from their own detector, apart from the interrupt path
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      comparator_status_reg <= 3'h0;
      adc_trigger <= 3'h0;
    end
    else
    begin
      comparator_status_reg <= inv_val;
      adc_trigger <= trg_event;
    end
  end

  // --------------------------------------------------------------------
  // analog routing and reference ladder
  // --------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      positive_source_select <= 6'h00;
      plus_own_connect <= 3'h0;
      plus_cmp0_connect <= 3'h0;
      plus_vref_connect <= 3'h0;
      minus_input_connect <= 3'h0;
      ref_ladder_enable <= 1'b0;
      reference_range_select <= 1'b0;
      ref_tap <= 4'h0;
      ref_tap_units <= 5'h00;
      ref_ladder_units <= `ANACMP_LADDER_LOW;
      cmp_zero_output_pin <= 1'b0;
      cmp_zero_output_oe <= 1'b0;
      cmp_one_output_pin <= 1'b0;
      cmp_one_output_oe <= 1'b0;
    end
    else
    begin
      minus_input_connect <= 3'h7;
      for (i = 0; i < 3; i = i + 1)
      begin
        positive_source_select[2*i +: 2] <= comparator_control_reg[i*`ANACMP_CTL_WIDTH+`ANACMP_CTL_SRC_LO +: 2];
        case (comparator_control_reg[i*`ANACMP_CTL_WIDTH+`ANACMP_CTL_SRC_LO +: 2])
          `ANACMP_SRC_OWN:
          begin
            plus_own_connect[i] <= 1'b1;
            plus_cmp0_connect[i] <= 1'b0;
            plus_vref_connect[i] <= 1'b0;
          end
          `ANACMP_SRC_CMP0:
          begin
            // comparator zero's own pin is comparator zero's plus pin
            plus_own_connect[i] <= (i == 0);
            plus_cmp0_connect[i] <= (i != 0);
            plus_vref_connect[i] <= 1'b0;
          end
          `ANACMP_SRC_VREF:
          begin
            plus_own_connect[i] <= 1'b0;
            plus_cmp0_connect[i] <= 1'b0;
            plus_vref_connect[i] <= 1'b1;
          end
          default:
          begin
            plus_own_connect[i] <= 1'b0;
            plus_cmp0_connect[i] <= 1'b0;
            plus_vref_connect[i] <= 1'b0;
          end
        endcase
      end
      ref_ladder_enable <= reference_control_reg[`ANACMP_REF_EN];
      reference_range_select <= reference_control_reg[`ANACMP_REF_RNG];
      ref_tap <= reference_control_reg[`ANACMP_REF_TAP_LO +: 4];
      if (!reference_control_reg[`ANACMP_REF_EN])
      begin
        ref_tap_units <= 5'h00;
        ref_ladder_units <= `ANACMP_LADDER_HIGH;
      end
      else if (reference_control_reg[`ANACMP_REF_RNG])
      begin
        ref_tap_units <= {1'b0, reference_control_reg[`ANACMP_REF_TAP_LO +: 4]};
        ref_ladder_units <= `ANACMP_LADDER_HIGH;
      end
      else
      begin
        ref_tap_units <= {1'b0, reference_control_reg[`ANACMP_REF_TAP_LO +: 4]} + `ANACMP_TAP_OFFSET;
        ref_ladder_units <= `ANACMP_LADDER_LOW;
      end
      // comparator zero has a dedicated pin, one shares its plus pin, two has none
      cmp_zero_output_pin <= inv_val[0];
      cmp_zero_output_oe <= 1'b1;
      cmp_one_output_pin <= inv_val[1];
      // released in the same cycle that the pin turns into comparator one's plus input
      cmp_one_output_oe <= (comparator_control_reg[`ANACMP_CTL_WIDTH+`ANACMP_CTL_SRC_LO +: 2] != `ANACMP_SRC_OWN);
    end
  end

endmodule

/* verification/anacmp_analog_model.sv */
// behavioural model of the analog comparators and pads at the block's far side
`timescale 1ns/1ps
module anacmp_analog_model
(
  input wire [2:0] level,
  output reg [2:0] compare_result,
  output reg cmp_one_plus_pin_in
);
  // analog results settle a few ns after the inputs move, unrelated to clk
  initial
  begin
    compare_result = 3'h0;
    cmp_one_plus_pin_in = 1'b0; // pad digital input kept off
  end
  always @(level)
    compare_result <= #3 level;
endmodule

/* verification/anacmp_top_properties.sv */
// assertions on the ports of the analog comparator control block
`timescale 1ns/1ps
module anacmp_checker
(
  input wire clk,
  input wire rst_n,
  input wire [2:0] compare_result,
  input wire [35:0] comparator_control_reg,
  input wire [2:0] comparator_status_reg,
  input wire [2:0] masked_irq_status_reg,
  input wire [2:0] raw_irq_status_reg,
  input wire [2:0] irq_enable_reg,
  input wire irq,
  input wire [5:0] positive_source_select,
  input wire [2:0] plus_vref_connect,
  input wire [2:0] minus_input_connect,
  input wire ref_ladder_enable,
  input wire reference_range_select,
  input wire [3:0] ref_tap,
  input wire [4:0] ref_tap_units,
  input wire [4:0] ref_ladder_units,
  input wire cmp_zero_output_pin,
  input wire cmp_one_output_oe
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ladder, routing, synchroniser, pin and interrupt status relations
  a_minus_fixed: assert property (rst_n [*4] |-> minus_input_connect == 3'h7)
    else $error("minus input not on its own pin");
  a_ladder_low: assert property (ref_ladder_enable && !reference_range_select |->
    ref_ladder_units == 5'h1f && ref_tap_units == {1'b0, ref_tap} + 5'h08) else $error("low range tap wrong");
  a_ladder_high: assert property (ref_ladder_enable && reference_range_select |->
    ref_ladder_units == 5'h17 && ref_tap_units == {1'b0, ref_tap}) else $error("high range tap wrong");
  a_ladder_off: assert property (!ref_ladder_enable |-> ref_tap_units == 5'h00)
    else $error("disabled reference not ground");
  a_vref_route: assert property (plus_vref_connect == {positive_source_select[5:4] == 2'h2,
    positive_source_select[3:2] == 2'h2, positive_source_select[1:0] == 2'h2}) else $error("reference route wrong");
  a_sync_hold: assert property ($changed(compare_result) && $stable(comparator_control_reg) |=>
    $stable(comparator_status_reg)) else $error("status moved before synchroniser");
  a_sync_settle: assert property (($stable(compare_result) && $stable(comparator_control_reg)) [*4] |->
    comparator_status_reg == (compare_result ^ {comparator_control_reg[25], comparator_control_reg[13],
    comparator_control_reg[1]})) else $error("status not the settled result");
  a_pin_zero: assert property (cmp_zero_output_pin == comparator_status_reg[0])
    else $error("comparator zero pin wrong");
  a_pin_one: assert property (cmp_one_output_oe == (positive_source_select[3:2] != 2'h0))
    else $error("comparator one pin enable wrong");
  a_irq_line: assert property (irq == |masked_irq_status_reg)
    else $error("irq not the or of masked status");
  a_masked_is_and: assert property (masked_irq_status_reg == (raw_irq_status_reg & irq_enable_reg))
    else $error("masked status not raw and enable");
endmodule
bind anacmp_top anacmp_checker u_chk (.clk, .rst_n, .compare_result, .comparator_control_reg,
  .comparator_status_reg, .masked_irq_status_reg, .raw_irq_status_reg, .irq_enable_reg, .irq,
  .positive_source_select, .plus_vref_connect,
  .minus_input_connect, .ref_ladder_enable, .reference_range_select, .ref_tap, .ref_tap_units,
  .ref_ladder_units, .cmp_zero_output_pin, .cmp_one_output_oe);

/* verification/anacmp_top_bench.sv */
// self-checking testbench for the analog comparator control block
`timescale 1ns/1ps
module anacmp_top_bench;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [2:0] level = 3'h0;
  reg [2:0] ctl_wr = 3'h0;
  reg [35:0] ctl_wdata = 36'h0;
  reg ref_wr = 1'b0;
  reg [9:0] ref_wdata = 10'h0;
  reg irq_enable_wr = 1'b0;
  reg [2:0] irq_enable_wdata = 3'h0;
  reg masked_irq_wr = 1'b0;
  reg [2:0] masked_irq_wdata = 3'h0;
  wire [2:0] compare_result, comparator_status_reg, irq_enable_reg, raw_irq_status_reg, masked_irq_status_reg;
  wire [2:0] plus_own_connect, plus_cmp0_connect, plus_vref_connect, minus_input_connect, adc_trigger;
  wire [35:0] comparator_control_reg;
  wire [9:0] reference_control_reg;
  wire [5:0] positive_source_select;
  wire [4:0] ref_tap_units, ref_ladder_units;
  wire cmp_one_plus_pin_in, irq, cmp_zero_output_pin, cmp_one_output_oe, cmp_zero_output_oe, cmp_one_output_pin;
  integer errors, tests_run, i, n;
  always #12.5 clk = ~clk;
  anacmp_analog_model far (.level, .compare_result, .cmp_one_plus_pin_in);
  anacmp_top dut (.clk, .rst_n, .compare_result, .cmp_one_plus_pin_in, .ctl_wr, .ctl_wdata, .ref_wr,
    .ref_wdata, .irq_enable_wr, .irq_enable_wdata, .masked_irq_wr, .masked_irq_wdata, .comparator_control_reg,
    .comparator_status_reg, .reference_control_reg, .irq_enable_reg, .raw_irq_status_reg,
    .masked_irq_status_reg, .irq, .positive_source_select, .plus_own_connect, .plus_cmp0_connect,
    .plus_vref_connect, .minus_input_connect, .ref_ladder_enable(), .reference_range_select(), .ref_tap(),
    .ref_tap_units, .ref_ladder_units, .cmp_zero_output_pin, .cmp_zero_output_oe, .cmp_one_output_pin,
    .cmp_one_output_oe, .adc_trigger);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // compare and count
  task check(input [35:0] seen, input [35:0] exp);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // one-cycle write then one idle cycle, so calls in a row never reassign a strobe at once
  // kinds: 0 control, 1 reference, 2 enable, 3 clear
  task wr(input [1:0] k, input [11:0] w);
  begin
    ctl_wdata = {3{w}};
    ref_wdata = w[9:0];
    irq_enable_wdata = w[2:0];
    masked_irq_wdata = w[2:0];
    ctl_wr = {3{k == 2'h0}};
    ref_wr = k == 2'h1;
    irq_enable_wr = k == 2'h2;
    masked_irq_wr = k == 2'h3;
    @(negedge clk);
    {ctl_wr, ref_wr, irq_enable_wr, masked_irq_wr} = 6'h00;
    @(negedge clk);
  end
  endtask
  task give_verdict;
  begin
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    errors = 0;
    tests_run = 0;
    repeat (2) @(negedge clk);
    check(comparator_control_reg, 36'h0);
    check({reference_control_reg, irq_enable_reg, raw_irq_status_reg, masked_irq_status_reg}, 36'h0);
    check(ref_ladder_units, 5'h1f);
    rst_n = 1'b1;
    $display("test reset done");
    // reference: off, low range, high range at both tap ends
    for (i = 0; i < 6; i = i + 1)
    begin
      n = (i % 2) ? 15 : 0;
      wr(2'h1, {2'h0, i >= 2, i >= 4, 4'h0, n[3:0]});
      repeat (2) @(negedge clk);
      check(reference_control_reg, {i >= 2, i >= 4, 4'h0, n[3:0]});
      check(ref_tap_units, i < 2 ? 0 : i < 4 ? n + 8 : n);
      check(ref_ladder_units, (i >= 2 && i < 4) ? 31 : 23);
    end
    $display("test reference done");
    // every plus source code on all three comparators
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(2'h0, i << 9);
      repeat (3) @(negedge clk);
      check(positive_source_select, {3{i[1:0]}});
      check(plus_vref_connect, {3{i == 2}});
      check({plus_cmp0_connect[2:1], plus_own_connect[2:1]}, {{2{i == 1}}, {2{i == 0}}});
      check(plus_own_connect[0] | plus_cmp0_connect[0], i < 2);
      check(minus_input_connect, 3'h7);
      check(cmp_one_output_oe, i != 0);
    end
    $display("test sources done");
    // interrupt on rising, trigger on falling, only comparator zero enabled
    wr(2'h0, 12'h828);
    repeat (3) @(negedge clk);
    wr(2'h3, 12'h007);
    wr(2'h2, 12'h001);
    check({irq_enable_reg, raw_irq_status_reg}, 6'h08);
    level = 3'h7;
    repeat (4) @(negedge clk);
    check({comparator_status_reg, cmp_zero_output_pin, cmp_zero_output_oe, cmp_one_output_pin}, 6'h3f);
    check(raw_irq_status_reg, 3'h7);
    check({masked_irq_status_reg, irq, adc_trigger}, 7'h18);
    wr(2'h3, 12'h000);
    check(masked_irq_status_reg, 3'h1);
    wr(2'h3, 12'h001);
    check({masked_irq_status_reg, irq}, 4'h0);
    level = 3'h0;
    n = 0;
    for (i = 0; i < 8; i = i + 1)
    begin
      @(negedge clk);
      if (adc_trigger === 3'h7)
        n = n + 1;
    end
    check(n, 1);
    check(raw_irq_status_reg, 3'h6);
    $display("test events done");
    give_verdict;
  end
endmodule
